// ===== logic/lfcb_cfg.svh
/*
  Constants of the frame control and data buffer block: indirect indices,
  control and status bit positions, reset values and buffer sizes.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef LFCB_CFG_SVH
`define LFCB_CFG_SVH

// ----------------------------------------
// Indirect register indices
// ----------------------------------------
`define LFCB_IDX_DATA_FIRST 8'h00
`define LFCB_IDX_DATA_LAST 8'h07
`define LFCB_IDX_CTRL 8'h08
`define LFCB_IDX_STATUS 8'h09
`define LFCB_IDX_ERROR 8'h0A

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define LFCB_CTRL_STOP 7
`define LFCB_CTRL_SLEEP 6
`define LFCB_CTRL_DIR 5
`define LFCB_CTRL_DATA_REQUEST_ACKNOWLEDGE 4
`define LFCB_CTRL_CLRINT 3
`define LFCB_CTRL_CLRERR 2
`define LFCB_CTRL_WUP 1
`define LFCB_CTRL_START 0

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define LFCB_ST_INT 3
`define LFCB_ST_ERR 2

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define LFCB_BYTE_W 8
`define LFCB_NUM_BYTES 8
`define LFCB_ERR_W 5
`define LFCB_FIFO_DEPTH 8
`define LFCB_RST_BYTE 8'h00

`endif

// ===== logic/lfcb_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an active-low async reset already synchronised.
*/
`timescale 1ns/1ps

module lfcb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  lfcb_strm_if.snk in_s,
  lfcb_strm_if.src out_s
);
  localparam int AW = $clog2(D);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic rdy;
  } lfcb_fifo_st_t;

  lfcb_fifo_st_t st_ff;
  lfcb_fifo_st_t nxt_st;
  logic push;
  logic pop;

  assign push = in_s.valid & st_ff.rdy;
  assign pop = out_s.ready & (st_ff.cnt != '0);
  assign in_s.ready = st_ff.rdy;
  assign out_s.valid = (st_ff.cnt != '0);
  assign out_s.data = st_ff.mem[st_ff.rd];

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wr] = in_s.data;
      nxt_st.wr = (st_ff.wr == AW'(D - 1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rd = (st_ff.rd == AW'(D - 1)) ? '0 : st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Ready registered so the source sees it straight from a flop
    nxt_st.rdy = (nxt_st.cnt != (AW+1)'(D));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.rdy <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ===== logic/lfcb_pkg.sv
/*
  Types of the frame control and data buffer block.
  Assumes the constants header is on the include path.
*/
`include "lfcb_cfg.svh"

package lfcb_pkg;

  // ----------------------------------------
  // Top state
  // ----------------------------------------
  typedef logic [`LFCB_BYTE_W-1:0] lfcb_byte_t;

  typedef struct packed {
    lfcb_byte_t idx;
    lfcb_byte_t rdata;
    lfcb_byte_t [`LFCB_NUM_BYTES-1:0] data;
    logic sleep;
    logic dir_tx;
    logic data_request_acknowledge;
    logic wakeup_send_request;
    logic frame_start_request;
    logic blocked;
    logic int_pend;
    logic err_flag;
    logic [`LFCB_ERR_W-1:0] err_bits;
    logic [3:0] rx_ptr;
    lfcb_byte_t tx_byte;
    logic abandon;
  } lfcb_top_st_t;

endpackage

// ===== logic/lfcb_strm_if.sv
/*
  Valid/ready byte stream between the top and its FIFO.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface lfcb_strm_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== logic/lfcb_top.sv
/*
  Frame control register and eight-byte frame data buffer of a LIN
  controller, reached through an index register and a data window.
  Assumes all inputs come from logic on CLK; ARST_N may be asynchronous.
*/
`timescale 1ns/1ps
`include "lfcb_cfg.svh"

//
// Contract
// - Master-only and slave-only bits follow current role
// - Control register at index 0x08, resets zero
// - Slave stop write blocks until sync break
// - Slave sleep bit selects sleep or wake
// - Direction bit: zero receive, one transmit
// - Device clears acknowledge bit once taken
// - Bit 3 write clears pending interrupt flag
// - Bit 2 write clears error flags
// - Bit 1 sends wakeup, self clears
// - Master bit 0 starts frame transmission
// - Start bit clears on completion or error
// - Index register selects target of data window
// - Error raises interrupt, abandons frame
// - Start and wakeup need error flag clear
module lfcb_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic IDX_WR,
  input wire logic WIN_WR,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  input wire logic MASTER_MODE,
  input wire logic FRAME_DONE,
  input wire logic ERR_DETECT,
  input wire logic [4:0] ERR_CAUSE,
  input wire logic INT_EVENT,
  input wire logic SYNC_BREAK,
  input wire logic ACK_TAKEN,
  input wire logic WAKEUP_SENT,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  input wire logic [2:0] TX_SEL,
  output logic [7:0] TX_BYTE,
  output logic START_REQ,
  output logic DIR_TX,
  output logic SLEEP_EN,
  output logic DATA_ACK,
  output logic WAKEUP_REQ,
  output logic PROC_BLOCKED,
  output logic INT_PENDING,
  output logic ERROR_FLAG,
  output logic FRAME_ABANDON
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rsync_ff;
  logic rst_n;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rsync_ff <= 2'h0;
    end
    else
    begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end

  assign rst_n = rsync_ff[1];

  // ----------------------------------------
  // Receive byte FIFO
  // ----------------------------------------
  lfcb_strm_if #(.W(`LFCB_BYTE_W)) rx_in ();
  lfcb_strm_if #(.W(`LFCB_BYTE_W)) rx_out ();

  assign rx_in.valid = RX_VALID;
  assign rx_in.data = RX_DATA;
  assign RX_READY = rx_in.ready;

  lfcb_fifo #(
    .W(`LFCB_BYTE_W),
    .D(`LFCB_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(CLK),
    .rst_n(rst_n),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  lfcb_pkg::lfcb_top_st_t st_ff;
  lfcb_pkg::lfcb_top_st_t nxt_st;

  logic win_data;
  logic win_ctrl;
  logic slave;
  logic buf_full;
  logic sw_byte_wr;
  logic drain;
  logic [7:0] ctrl_rd;
  logic [7:0] status_rd;
  logic [7:0] rd_mux;

  assign slave = ~MASTER_MODE;
  assign win_data = (st_ff.idx <= `LFCB_IDX_DATA_LAST);
  assign win_ctrl = (st_ff.idx == `LFCB_IDX_CTRL);
  assign sw_byte_wr = WIN_WR & win_data;
  assign buf_full = (st_ff.rx_ptr == 4'(`LFCB_NUM_BYTES));
  // Software byte writes take the buffer port, so the FIFO stalls then
  assign rx_out.ready = ~sw_byte_wr & (~buf_full | st_ff.blocked);
  assign drain = rx_out.valid & rx_out.ready;

  // ----------------------------------------
  // Readback views
  // ----------------------------------------
  always_comb
  begin
    ctrl_rd = `LFCB_RST_BYTE;
    // Stop and clear bits read zero
    ctrl_rd[`LFCB_CTRL_SLEEP] = st_ff.sleep;
    ctrl_rd[`LFCB_CTRL_DIR] = st_ff.dir_tx;
    ctrl_rd[`LFCB_CTRL_DATA_REQUEST_ACKNOWLEDGE] = st_ff.data_request_acknowledge;
    ctrl_rd[`LFCB_CTRL_WUP] = st_ff.wakeup_send_request;
    ctrl_rd[`LFCB_CTRL_START] = st_ff.frame_start_request;
    status_rd = `LFCB_RST_BYTE;
    status_rd[`LFCB_ST_INT] = st_ff.int_pend;
    status_rd[`LFCB_ST_ERR] = st_ff.err_flag;
  end

  always_comb
  begin
    if (win_data)
    begin
      rd_mux = st_ff.data[st_ff.idx[2:0]];
    end
    else
    begin
      case (st_ff.idx)
        `LFCB_IDX_CTRL:
        begin
          rd_mux = ctrl_rd;
        end
        `LFCB_IDX_STATUS:
        begin
          rd_mux = status_rd;
        end
        `LFCB_IDX_ERROR:
        begin
          rd_mux = {3'h0, st_ff.err_bits};
        end
        default:
        begin
          rd_mux = `LFCB_RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic wr_ctrl;
    logic err_ev;
    wr_ctrl = WIN_WR & win_ctrl;
    err_ev = ERR_DETECT;
    nxt_st = st_ff;
    nxt_st.abandon = err_ev;

    if (IDX_WR)
    begin
      nxt_st.idx = BUS_WDATA;
    end

    // Data buffer: software write or drained receive byte
    if (sw_byte_wr)
    begin
      nxt_st.data[st_ff.idx[2:0]] = BUS_WDATA;
    end
    else if (drain & ~st_ff.blocked)
    begin
      nxt_st.data[st_ff.rx_ptr[2:0]] = rx_out.data;
      nxt_st.rx_ptr = st_ff.rx_ptr + 4'h1;
    end

    // Hardware clears of self-clearing bits
    if (ACK_TAKEN)
    begin
      nxt_st.data_request_acknowledge = 1'b0;
    end
    if (WAKEUP_SENT)
    begin
      nxt_st.wakeup_send_request = 1'b0;
    end
    if (FRAME_DONE)
    begin
      nxt_st.frame_start_request = 1'b0;
    end

    // Control register writes
    if (wr_ctrl)
    begin
      nxt_st.dir_tx = BUS_WDATA[`LFCB_CTRL_DIR];
      if (slave)
      begin
        nxt_st.sleep = BUS_WDATA[`LFCB_CTRL_SLEEP];
        if (BUS_WDATA[`LFCB_CTRL_DATA_REQUEST_ACKNOWLEDGE])
        begin
          nxt_st.data_request_acknowledge = 1'b1;
        end
        if (BUS_WDATA[`LFCB_CTRL_STOP])
        begin
          nxt_st.blocked = 1'b1;
        end
      end
      if (BUS_WDATA[`LFCB_CTRL_CLRINT])
      begin
        nxt_st.int_pend = 1'b0;
      end
      if (BUS_WDATA[`LFCB_CTRL_CLRERR])
      begin
        nxt_st.err_flag = 1'b0;
        nxt_st.err_bits = '0;
      end
      // Error flag checked before accepting start or wakeup
      if (BUS_WDATA[`LFCB_CTRL_WUP] & ~st_ff.err_flag)
      begin
        nxt_st.wakeup_send_request = 1'b1;
      end
      if (BUS_WDATA[`LFCB_CTRL_START] & MASTER_MODE & ~st_ff.err_flag)
      begin
        nxt_st.frame_start_request = 1'b1;
        nxt_st.rx_ptr = 4'h0;
      end
    end

    // Sync break lifts the stop block and restarts byte capture
    if (SYNC_BREAK)
    begin
      nxt_st.rx_ptr = 4'h0;
      if (~(wr_ctrl & slave & BUS_WDATA[`LFCB_CTRL_STOP]))
      begin
        nxt_st.blocked = 1'b0;
      end
    end

    // Events win over a same-cycle clear
    if (INT_EVENT | err_ev)
    begin
      nxt_st.int_pend = 1'b1;
    end
    if (err_ev)
    begin
      nxt_st.err_flag = 1'b1;
      nxt_st.err_bits = nxt_st.err_bits | ERR_CAUSE;
      // Abandon the frame even if a start was written this cycle
      nxt_st.frame_start_request = 1'b0;
    end

    nxt_st.rdata = rd_mux;
    nxt_st.tx_byte = st_ff.data[TX_SEL];
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign BUS_RDATA = st_ff.rdata;
  assign TX_BYTE = st_ff.tx_byte;
  assign START_REQ = st_ff.frame_start_request;
  assign DIR_TX = st_ff.dir_tx;
  assign SLEEP_EN = st_ff.sleep;
  assign DATA_ACK = st_ff.data_request_acknowledge;
  assign WAKEUP_REQ = st_ff.wakeup_send_request;
  assign PROC_BLOCKED = st_ff.blocked;
  assign INT_PENDING = st_ff.int_pend;
  assign ERROR_FLAG = st_ff.err_flag;
  assign FRAME_ABANDON = st_ff.abandon;

endmodule

// ===== testbench/lfcb_bus_model.sv
/*
  Far side: frame engine answers and a receive byte source.
  Assumes go and slow change at falling edges.
*/
`timescale 1ns/1ps

module lfcb_bus_model (
  input wire logic CLK,
  input wire logic go,
  input wire logic slow,
  input wire logic START_REQ,
  input wire logic DATA_ACK,
  input wire logic WAKEUP_REQ,
  input wire logic RX_READY,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic FRAME_DONE,
  output logic ACK_TAKEN,
  output logic WAKEUP_SENT
);
  logic [7:0] seq = 8'h30;
  logic [4:0] cnt = 5'h00;
  logic busy;
  // Done, ack-taken and wakeup-sent pulses, one driver for all three
  logic [2:0] ev = 3'b000;
  // ----
  // Behaviour
  // ----
  // Idle data inverted so a stale byte never passes
  assign RX_VALID = go;
  assign RX_DATA = go ? seq : ~seq;
  assign busy = (START_REQ | DATA_ACK | WAKEUP_REQ) & ~(FRAME_DONE | ACK_TAKEN | WAKEUP_SENT);
  assign {FRAME_DONE, ACK_TAKEN, WAKEUP_SENT} = ev;
  always @(posedge CLK)
  begin
    if (RX_VALID && RX_READY)
      seq <= seq + 8'h01;
    ev <= 3'b000;
    // Restart the count when a request is dropped early, e.g. by an error
    if (busy)
      cnt <= cnt + 5'h01;
    else
      cnt <= 5'h00;
    if (busy && cnt == (slow ? 5'h14 : 5'h02))
    begin
      cnt <= 5'h00;
      ev[2] <= START_REQ;
      ev[1] <= DATA_ACK;
      ev[0] <= WAKEUP_REQ;
    end
  end
endmodule

// ===== testbench/lfcb_top_asserts.sv
/*
  Port checker of the frame control block.
  Assumes it is bound onto lfcb_top, one clock domain.
*/
`timescale 1ns/1ps

module lfcb_top_asserts (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic WIN_WR,
  input wire logic MASTER_MODE,
  input wire logic FRAME_DONE,
  input wire logic ERR_DETECT,
  input wire logic SYNC_BREAK,
  input wire logic ACK_TAKEN,
  input wire logic WAKEUP_SENT,
  input wire logic START_REQ,
  input wire logic SLEEP_EN,
  input wire logic DATA_ACK,
  input wire logic WAKEUP_REQ,
  input wire logic PROC_BLOCKED,
  input wire logic INT_PENDING,
  input wire logic ERROR_FLAG,
  input wire logic FRAME_ABANDON
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ----
  // Relations
  // ----
  a_done_ends_start: assert property (FRAME_DONE && !WIN_WR |=> !START_REQ)
    else $error("start held after done");
  a_err_ends_start: assert property (ERR_DETECT |=> !START_REQ)
    else $error("start held after error");
  a_err_raises_flags: assert property (ERR_DETECT |=> INT_PENDING && ERROR_FLAG)
    else $error("error flags missing");
  a_abandon_cause: assert property (FRAME_ABANDON |-> $past(ERR_DETECT))
    else $error("abandon without error");
  a_ack_clears: assert property (ACK_TAKEN && !WIN_WR |=> !DATA_ACK)
    else $error("ack bit stuck");
  a_wakeup_clears: assert property (WAKEUP_SENT && !WIN_WR |=> !WAKEUP_REQ)
    else $error("wakeup bit stuck");
  a_start_allowed: assert property ($rose(START_REQ) |->
    $past(WIN_WR) && $past(MASTER_MODE) && !$past(ERROR_FLAG))
    else $error("start set illegally");
  a_wakeup_allowed: assert property ($rose(WAKEUP_REQ) |-> !$past(ERROR_FLAG))
    else $error("wakeup during error");
  a_sleep_role: assert property ($changed(SLEEP_EN) |-> !$past(MASTER_MODE))
    else $error("sleep moved in master");
  a_ack_role: assert property ($rose(DATA_ACK) |-> !$past(MASTER_MODE))
    else $error("ack set in master");
  a_block_start: assert property ($rose(PROC_BLOCKED) |->
    $past(WIN_WR) && !$past(MASTER_MODE))
    else $error("block without slave write");
  a_block_ends: assert property (SYNC_BREAK && !WIN_WR |=> !PROC_BLOCKED)
    else $error("block outlived break");
endmodule

bind lfcb_top lfcb_top_asserts chk_u (.CLK, .ARST_N, .WIN_WR, .MASTER_MODE,
  .FRAME_DONE, .ERR_DETECT, .SYNC_BREAK, .ACK_TAKEN, .WAKEUP_SENT, .START_REQ,
  .SLEEP_EN, .DATA_ACK, .WAKEUP_REQ, .PROC_BLOCKED, .INT_PENDING, .ERROR_FLAG,
  .FRAME_ABANDON);

// ===== testbench/tb_top.sv
/*
  Self-checking bench of the frame control block.
  Assumes the bus model answers frame, ack and wakeup requests.
*/
`timescale 1ns/1ps

module tb_top;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic IDX_WR, WIN_WR, MASTER_MODE, ERR_DETECT, INT_EVENT, SYNC_BREAK, go, slow;
  logic [7:0] BUS_WDATA, BUS_RDATA, RX_DATA, TX_BYTE, fl;
  logic [4:0] ERR_CAUSE;
  logic [2:0] TX_SEL;
  logic FRAME_DONE, ACK_TAKEN, WAKEUP_SENT, RX_VALID, RX_READY, START_REQ, DIR_TX;
  logic SLEEP_EN, DATA_ACK, WAKEUP_REQ, PROC_BLOCKED, INT_PENDING, ERROR_FLAG, FRAME_ABANDON;
  int fail_count = 0;
  int checked = 0;

  always #20 CLK = ~CLK;
  // Flags laid out like the control bits for one-shot compares
  assign fl = {PROC_BLOCKED, SLEEP_EN, DIR_TX, DATA_ACK, INT_PENDING, ERROR_FLAG,
    WAKEUP_REQ, START_REQ};

  lfcb_top dut_u (.CLK, .ARST_N, .IDX_WR, .WIN_WR, .BUS_WDATA, .BUS_RDATA, .MASTER_MODE,
    .FRAME_DONE, .ERR_DETECT, .ERR_CAUSE, .INT_EVENT, .SYNC_BREAK, .ACK_TAKEN,
    .WAKEUP_SENT, .RX_VALID, .RX_DATA, .RX_READY, .TX_SEL, .TX_BYTE, .START_REQ, .DIR_TX,
    .SLEEP_EN, .DATA_ACK, .WAKEUP_REQ, .PROC_BLOCKED, .INT_PENDING, .ERROR_FLAG,
    .FRAME_ABANDON);
  lfcb_bus_model bus_u (.CLK, .go, .slow, .START_REQ, .DATA_ACK, .WAKEUP_REQ, .RX_READY,
    .RX_VALID, .RX_DATA, .FRAME_DONE, .ACK_TAKEN, .WAKEUP_SENT);

  // ----
  // Helpers
  // ----
  task automatic close_out();
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    IDX_WR = 1'b1;
    BUS_WDATA = a;
    tick(1);
    IDX_WR = 1'b0;
    WIN_WR = 1'b1;
    BUS_WDATA = d;
    tick(1);
    WIN_WR = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    IDX_WR = 1'b1;
    BUS_WDATA = a;
    tick(1);
    IDX_WR = 1'b0;
    tick(1);
    chk("window", e, BUS_RDATA);
  endtask

  // Bounded wait for masked flags, then compare
  task automatic settle(input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 40 && (fl & m) !== e; i++)
      tick(1);
    chk("flags", e, fl & m);
  endtask

  task automatic brk();
    SYNC_BREAK = 1'b1;
    tick(1);
    SYNC_BREAK = 1'b0;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_data();
    for (int i = 0; i < 9; i++)
      rd(8'(i), 8'h00);
    rd(8'h0F, 8'h00);
    for (int i = 0; i < 8; i++)
      wr(8'(i), 8'(i * 29 + 90));
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i), 8'(i * 29 + 90));
      TX_SEL = 3'(i);
      tick(1);
      chk("tx", 8'(i * 29 + 90), TX_BYTE);
    end
  endtask

  task automatic t_roles();
    MASTER_MODE = 1'b1;
    slow = 1'b1;
    wr(8'h08, 8'hFF);
    chk("flags", 8'h23, fl);
    rd(8'h08, 8'h23);
    settle(8'h03, 8'h00);
    MASTER_MODE = 1'b0;
    wr(8'h08, 8'hF1);
    chk("flags", 8'hF0, fl);
    rd(8'h08, 8'h70);
    settle(8'h10, 8'h00);
    brk();
    chk("flags", 8'h60, fl);
    wr(8'h08, 8'h00);
    chk("flags", 8'h00, fl);
  endtask

  task automatic t_error();
    MASTER_MODE = 1'b1;
    wr(8'h08, 8'h01);
    ERR_DETECT = 1'b1;
    ERR_CAUSE = 5'h15;
    tick(1);
    ERR_DETECT = 1'b0;
    ERR_CAUSE = 5'h00;
    chk("flags", 8'h0C, fl);
    chk("abandon", 8'h01, {7'h00, FRAME_ABANDON});
    rd(8'h0A, 8'h15);
    rd(8'h09, 8'h0C);
    wr(8'h08, 8'h03);
    chk("flags", 8'h0C, fl);
    wr(8'h08, 8'h04);
    chk("flags", 8'h08, fl);
    rd(8'h0A, 8'h00);
    wr(8'h08, 8'h08);
    chk("flags", 8'h00, fl);
    INT_EVENT = 1'b1;
    tick(1);
    INT_EVENT = 1'b0;
    chk("flags", 8'h08, fl);
    wr(8'h08, 8'h08);
    chk("flags", 8'h00, fl);
  endtask

  // Fills buffer and FIFO until refused, then drains after a break
  task automatic t_rx();
    MASTER_MODE = 1'b0;
    slow = 1'b0;
    brk();
    go = 1'b1;
    for (int i = 0; i < 80 && RX_READY === 1'b1; i++)
      tick(1);
    go = 1'b0;
    chk("ready", 8'h00, {7'h00, RX_READY});
    for (int i = 0; i < 8; i++)
    begin
      TX_SEL = 3'(i);
      tick(1);
      chk("rx", 8'h30 + 8'(i), TX_BYTE);
    end
    brk();
    tick(20);
    for (int i = 0; i < 8; i++)
      rd(8'(i), 8'h38 + 8'(i));
    chk("ready", 8'h01, {7'h00, RX_READY});
    // Bytes offered while stopped are dropped, not queued for later
    wr(8'h08, 8'h80);
    chk("flags", 8'h80, fl);
    go = 1'b1;
    tick(4);
    go = 1'b0;
    tick(6);
    brk();
    tick(10);
    chk("flags", 8'h00, fl);
    rd(8'h00, 8'h38);
  endtask

  initial
  begin
    {IDX_WR, WIN_WR, MASTER_MODE, ERR_DETECT, INT_EVENT, SYNC_BREAK, go, slow} = 8'h00;
    BUS_WDATA = 8'h00;
    ERR_CAUSE = 5'h00;
    TX_SEL = 3'h0;
    tick(12);
    ARST_N = 1'b1;
    tick(3);
    t_data();
    t_roles();
    t_error();
    t_rx();
    close_out();
  end

  // Run needs about 230 cycles
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule
